// *** dv/axis_model.sv ***
// Far-side model: reference switch, travel limits and encoder index
`timescale 1ns/1ns
`default_nettype none
module axis_model (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic signed [15:0] speed_cmd,
  output var  logic               ref_sw,
  output var  logic               ccw_lim,
  output var  logic               cw_lim,
  output var  logic               index,
  output var  logic signed [31:0] pos_r
);
  logic [3:0] div_r;
  // One count each 16 cycles, CCW positive; slow so events stay stable
  always_ff @(posedge mclk) begin
    div_r <= srst ? 4'h0 : div_r + 4'h1;
    if (srst)
      pos_r <= 32'sh0;
    else if (div_r == 4'hf && speed_cmd != 16'sh0)
      pos_r <= pos_r + (speed_cmd > 16'sh0 ? 32'sh1 : -32'sh1);
  end
  // Switch high and limits low from 20 counts out; index every 8 counts
  assign ref_sw  = pos_r >= 32'sd20 || pos_r <= -32'sd20;
  assign ccw_lim = pos_r < 32'sd20;
  assign cw_lim  = pos_r > -32'sd20;
  assign index   = pos_r[2:0] == 3'h0;
endmodule
`default_nettype wire

// *** dv/servo_homing_sequencer_tb.sv ***
// Self-checking bench of the homing sequencer
`timescale 1ns/1ns
`default_nettype none
module servo_homing_sequencer_tb;
  import homing_pkg::*;
  localparam int MSC = 4;
  logic               mclk = 1'b0;
  logic               srst = 1'b1;
  logic               wr_stb = 1'b0;
  logic               rd_stb = 1'b0;
  logic               req = 1'b0;
  logic        [5:0]  addr = 6'h00;
  logic        [31:0] wdata = 32'h0;
  logic        [31:0] rdata;
  logic               sw, cl, wl, idx, busy, done, ci, wi, ce, irq;
  logic signed [31:0] pos, org;
  logic signed [15:0] spd;
  int                 miscompares = 0;
  int                 comparisons = 0;
  int                 n, hi, lo, ex, fnd, t, r, o;
  longint             t0;
  servo_homing_sequencer #(.MS_CYCLES(MSC)) DUT (.mclk(mclk), .srst(srst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .homing_request_input(req), .ref_switch_input(sw),
    .ccw_travel_limit_input(cl), .cw_travel_limit_input(wl),
    .encoder_index_input(idx), .position_count(pos), .speed_cmd(spd),
    .homing_busy(busy), .homing_done(done), .ccw_inhibit_en(ci),
    .cw_inhibit_en(wi), .cmd_enable(ce), .origin_position(org), .irq(irq));
  axis_model far_side (.mclk(mclk), .srst(srst), .speed_cmd(spd),
    .ref_sw(sw), .ccw_lim(cl), .cw_lim(wl), .index(idx), .pos_r(pos));
  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and the single compare
  task automatic end_sim;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register port cycles and a bounded wait
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(posedge mclk);
    chk(rdata, e);
  endtask
  task automatic waitv(ref logic s, input logic v);
    for (n = 0; n < 5000 && s !== v; n++)
      @(posedge mclk);
    if (s !== v) begin
      miscompares++;
      end_sim();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Defaults, disabled trigger, then every reference and origin mode
  initial begin
    void'($urandom(80593));
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    rd(REG_SPEED, 32'h0032_01f4);
    rd(REG_SETTLE, 32'h0000_0032);
    rd(REG_HOLD, 32'h0000_0064);
    rd(6'h3c, 32'h0);
    req <= 1'b1;
    repeat (20) @(posedge mclk);
    chk(busy, 1'b0);
    for (int k = 0; k < 18; k++) begin
      r = k / 3;
      o = k % 3;
      t = (k + r) % 3 + 1;
      srst <= 1'b1;
      req  <= 1'b0;
      repeat (10) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      hi = $urandom_range(65535) - 32768;
      lo = $urandom_range(19998) - 9999;
      fnd = r < 4 ? 20 : 8;
      if (o == 1) fnd = (fnd / 8 + 1) * 8;
      if (o == 0) fnd = (fnd - 1) / 8 * 8;
      ex = (r[0] ? -fnd : fnd) + hi * 10000 + lo;
      wr(REG_OFFS_HI, hi);
      wr(REG_OFFS_LO, lo);
      wr(REG_SPEED, 32'h001e_012c);
      wr(REG_ACCEL, k == 17 ? 32'h0000_0bb8 : 32'h0);
      wr(REG_DECEL, 32'h0);
      wr(REG_IRQ_MASK, 32'h4);
      wr(REG_CTRL, 32'({k[0], o[1:0], r[2:0], t[1:0]}));
      req <= (t != 3);
      waitv(busy, 1'b1);
      @(posedge mclk);
      chk(32'(spd), 32'(k == 17 ? 0 : r[0] ? -300 : 300));
      chk(ci, r != 2);
      chk(wi, r != 3);
      chk(ce, 1'b0);
      // Accel 3000 ms to rated 3000 r/min: about 1 r/min per ms
      if (k == 17) begin
        repeat (42) @(posedge mclk);
        chk(spd >= -16'sd11 && spd <= -16'sd9, 1'b1);
      end
      // A fresh edge while busy must be dropped
      if (t == 2) req <= 1'b0;
      repeat (4) @(posedge mclk);
      req <= (t != 3);
      waitv(done, 1'b1);
      t0 = $time;
      chk(org, ex);
      chk(busy, 1'b0);
      chk(ce, k[0]);
      chk({ci, wi}, 2'h3);
      rd(REG_IRQ_STAT, 32'h7);
      chk(irq, 1'b1);
      wr(REG_IRQ_STAT, 32'h7);
      @(posedge mclk);
      chk(irq, 1'b0);
      if (t == 1) req <= 1'b0;
      waitv(done, 1'b0);
      n = int'(($time - t0) / 10);
      if (t != 1) chk(n >= 100 * MSC - 1 && n <= 100 * MSC + 1, 1'b1);
      req <= 1'b0;
      repeat (20) @(posedge mclk);
      chk(busy, 1'b0);
      chk(ce, 1'b1);
    end
    end_sim();
  end
endmodule
`default_nettype wire

// *** verilog/homing_pkg.sv ***
// Shared constants and types of the homing sequencer
`default_nettype none
package homing_pkg;

  // Register byte addresses
  localparam logic [5:0] REG_CTRL     = 6'h00;
  localparam logic [5:0] REG_SPEED    = 6'h04;
  localparam logic [5:0] REG_OFFS_HI  = 6'h08;
  localparam logic [5:0] REG_OFFS_LO  = 6'h0c;
  localparam logic [5:0] REG_ACCEL    = 6'h10;
  localparam logic [5:0] REG_DECEL    = 6'h14;
  localparam logic [5:0] REG_SETTLE   = 6'h18;
  localparam logic [5:0] REG_HOLD     = 6'h1c;
  localparam logic [5:0] REG_STATUS   = 6'h20;
  localparam logic [5:0] REG_IRQ_STAT = 6'h24;
  localparam logic [5:0] REG_IRQ_MASK = 6'h28;
  localparam logic [5:0] REG_ORIGIN   = 6'h2c;

  // Control and speed register fields
  localparam int CTRL_TRIG_LSB = 0;
  localparam int CTRL_REF_LSB  = 2;
  localparam int CTRL_ORG_LSB  = 5;
  localparam int CTRL_POST_BIT = 7;
  localparam int SPEED_2ND_LSB = 16;

  // Trigger, reference and origin mode codes
  localparam logic [1:0] TRIG_OFF     = 2'h0;
  localparam logic [1:0] TRIG_LEVEL   = 2'h1;
  localparam logic [1:0] TRIG_EDGE    = 2'h2;
  localparam logic [1:0] TRIG_POWERUP = 2'h3;
  localparam logic [2:0] REF_SW_CCW   = 3'h0;
  localparam logic [2:0] REF_SW_CW    = 3'h1;
  localparam logic [2:0] REF_CCW_LIM  = 3'h2;
  localparam logic [2:0] REF_CW_LIM   = 3'h3;
  localparam logic [2:0] REF_IDX_CCW  = 3'h4;
  localparam logic [2:0] REF_IDX_CW   = 3'h5;
  localparam logic [1:0] ORG_BACK     = 2'h0;
  localparam logic [1:0] ORG_FWD      = 2'h1;
  localparam logic [1:0] ORG_REF      = 2'h2;

  // Reset values of the settings and the offset scale
  localparam logic [15:0] FIRST_SPEED_RST  = 16'h01f4;
  localparam logic [15:0] SECOND_SPEED_RST = 16'h0032;
  localparam logic [15:0] SETTLE_MS_RST    = 16'h0032;
  localparam logic [15:0] HOLD_MS_RST      = 16'h0064;
  localparam int          OFFSET_SCALE     = 10000;

  // Interrupt status bits
  localparam int IRQ_REF  = 0;
  localparam int IRQ_ORG  = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_W    = 3;

  // Timing: millisecond base at the control clock rate, and default rated speed
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MS_NS          = 1000000;
  localparam int MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
  localparam int RATED_RPM_DFLT = 3000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEEK_REF,
    ST_SEEK_ORG,
    ST_SETTLE,
    ST_HOLD
  } state_t;

endpackage
`default_nettype wire

// *** verilog/servo_homing_sequencer.sv ***
// Homing sequencer of a servo drive with register port and interrupt
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Trigger mode 0 disables, 1 level, 2 rising edge, 3 once at power-up.
// - Reference mode picks switch rise, limit fall or index, CCW or CW.
// - Homing moves at first speed toward the reference until its event.
// - A limit used as reference has its inhibit lifted while homing runs.
// - After the reference, second speed is used to find the origin.
// - Origin mode 0 index backward, 1 index forward, 2 reference itself.
// - Final origin is found origin plus high times 10000 plus low offset.
// - First speed is 1 to 3000 r/min, reset value 500; the register takes any 16-bit value.
// - Homing acceleration ramps at rated speed per accel time.
// - Homing deceleration ramps at rated speed per decel time.
// - After the origin a settle delay passes before done is raised.
// - In edge and power-up modes done stays for the hold time.
// - Post mode 0 resumes commands after done drops, 1 at completion.
////////////////////////////////////////////////////////////////////////////////
module servo_homing_sequencer
  import homing_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DFLT,
  parameter int unsigned RATED_RPM = RATED_RPM_DFLT
) (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic        [5:0]  addr,
  input  wire logic        [31:0] wdata,
  input  wire logic               wr_stb,
  input  wire logic               rd_stb,
  output var  logic        [31:0] rdata,
  input  wire logic               homing_request_input,
  input  wire logic               ref_switch_input,
  input  wire logic               ccw_travel_limit_input,
  input  wire logic               cw_travel_limit_input,
  input  wire logic               encoder_index_input,
  input  wire logic signed [31:0] position_count,
  output var  logic signed [15:0] speed_cmd,
  output var  logic               homing_busy,
  output var  logic               homing_done,
  output var  logic               ccw_inhibit_en,
  output var  logic               cw_inhibit_en,
  output var  logic               cmd_enable,
  output var  logic signed [31:0] origin_position,
  output var  logic               irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic        [1:0]  homing_trigger_mode;
  logic        [2:0]  homing_reference_mode;
  logic        [1:0]  homing_origin_mode;
  logic               post_homing_command_mode;
  logic        [15:0] homing_first_speed;
  logic        [15:0] homing_second_speed;
  logic signed [15:0] origin_offset_high;
  logic signed [15:0] origin_offset_low;
  logic        [15:0] homing_accel_time;
  logic        [15:0] homing_decel_time;
  logic        [15:0] homing_settle_delay;
  logic        [15:0] homing_done_hold_time;
  logic [IRQ_W-1:0]   irq_stat_r;
  logic [IRQ_W-1:0]   irq_mask_r;
  logic [IRQ_W-1:0]   irq_stat_nxt;
  logic [IRQ_W-1:0]   irq_evt;
  logic [31:0]        rd_mux;
  state_t             state_r;
  state_t             state_nxt;
  logic               req_s1_r;
  logic               req_s2_r;
  logic               req_prev_r;
  logic               ref_prev_r;
  logic               ccw_lim_prev_r;
  logic               cw_lim_prev_r;
  logic               idx_prev_r;
  logic               pwrup_pend_r;
  logic [31:0]        div_cnt_r;
  logic               ms_tick;
  logic [15:0]        ms_cnt_r;
  logic               state_chg;
  logic               req_rise;
  logic               ref_rise;
  logic               ccw_lim_fall;
  logic               cw_lim_fall;
  logic               idx_rise;
  logic               ref_evt;
  logic               start_req;
  logic               ref_found;
  logic               org_found;
  logic               settle_over;
  logic               hold_over;
  logic               dir1_cw;
  logic               dir2_cw;
  logic signed [15:0] target;
  logic               busy_nxt;
  logic               done_nxt;
  logic               wr_ctrl;
  logic               wr_speed;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Signed speed command from magnitude and direction, CCW positive
  function automatic logic signed [15:0] dir_speed(
    input logic [15:0] mag,
    input logic        cw
  );
    return cw ? -signed'(mag) : signed'(mag);
  endfunction

  // Pulse offset from its high and low parts
  function automatic logic signed [31:0] pulse_offset(
    input logic signed [15:0] hi,
    input logic signed [15:0] lo
  );
    return (32'(hi) * 32'(OFFSET_SCALE)) + 32'(lo);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  assign wr_ctrl  = wr_stb && addr == REG_CTRL;
  assign wr_speed = wr_stb && addr == REG_SPEED;

  // Settings writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      homing_trigger_mode      <= TRIG_OFF;
      homing_reference_mode    <= REF_SW_CCW;
      homing_origin_mode       <= ORG_BACK;
      post_homing_command_mode <= 1'b0;
      homing_first_speed       <= FIRST_SPEED_RST;
      homing_second_speed      <= SECOND_SPEED_RST;
      origin_offset_high       <= 16'sh0;
      origin_offset_low        <= 16'sh0;
      homing_accel_time        <= 16'h0;
      homing_decel_time        <= 16'h0;
      homing_settle_delay      <= SETTLE_MS_RST;
      homing_done_hold_time    <= HOLD_MS_RST;
      irq_mask_r               <= '0;
    end else if (wr_stb) begin
      if (wr_ctrl) begin
        homing_trigger_mode      <= wdata[CTRL_TRIG_LSB +: 2];
        homing_reference_mode    <= wdata[CTRL_REF_LSB +: 3];
        homing_origin_mode       <= wdata[CTRL_ORG_LSB +: 2];
        post_homing_command_mode <= wdata[CTRL_POST_BIT];
      end
      if (wr_speed) begin
        homing_first_speed  <= wdata[15:0];
        homing_second_speed <= wdata[SPEED_2ND_LSB +: 16];
      end
      if (addr == REG_OFFS_HI) origin_offset_high <= wdata[15:0];
      if (addr == REG_OFFS_LO) origin_offset_low <= wdata[15:0];
      if (addr == REG_ACCEL) homing_accel_time <= wdata[15:0];
      if (addr == REG_DECEL) homing_decel_time <= wdata[15:0];
      if (addr == REG_SETTLE) homing_settle_delay <= wdata[15:0];
      if (addr == REG_HOLD) homing_done_hold_time <= wdata[15:0];
      if (addr == REG_IRQ_MASK) irq_mask_r <= wdata[IRQ_W-1:0];
    end
  end

  // Read selection, unmapped addresses read zero
  assign rd_mux =
    (addr == REG_CTRL)   ? {24'h0, post_homing_command_mode,
                            homing_origin_mode, homing_reference_mode,
                            homing_trigger_mode} :
    (addr == REG_SPEED)  ? {homing_second_speed, homing_first_speed} :
    (addr == REG_OFFS_HI) ? 32'(origin_offset_high) :
    (addr == REG_OFFS_LO) ? 32'(origin_offset_low) :
    (addr == REG_ACCEL)  ? {16'h0, homing_accel_time} :
    (addr == REG_DECEL)  ? {16'h0, homing_decel_time} :
    (addr == REG_SETTLE) ? {16'h0, homing_settle_delay} :
    (addr == REG_HOLD)   ? {16'h0, homing_done_hold_time} :
    (addr == REG_STATUS) ? {speed_cmd, 10'h0, 3'(state_r),
                            cmd_enable, homing_done, homing_busy} :
    (addr == REG_IRQ_STAT) ? {29'h0, irq_stat_r} :
    (addr == REG_IRQ_MASK) ? {29'h0, irq_mask_r} :
    (addr == REG_ORIGIN) ? origin_position : 32'h0;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (srst) rdata <= 32'h0;
    else rdata <= rd_stb ? rd_mux : 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling and edge detection

  assign req_rise  = req_s2_r && !req_prev_r;
  assign ref_rise  = ref_switch_input && !ref_prev_r;
  assign ccw_lim_fall = !ccw_travel_limit_input && ccw_lim_prev_r;
  assign cw_lim_fall  = !cw_travel_limit_input && cw_lim_prev_r;
  assign idx_rise  = encoder_index_input && !idx_prev_r;

  // Request synchroniser and previous levels of the other inputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      req_s1_r    <= 1'b0;
      req_s2_r    <= 1'b0;
      req_prev_r  <= 1'b0;
      ref_prev_r  <= 1'b0;
      ccw_lim_prev_r <= 1'b0;
      cw_lim_prev_r  <= 1'b0;
      idx_prev_r  <= 1'b0;
    end else begin
      req_s1_r    <= homing_request_input;
      req_s2_r    <= req_s1_r;
      req_prev_r  <= req_s2_r;
      ref_prev_r  <= ref_switch_input;
      ccw_lim_prev_r <= ccw_travel_limit_input;
      cw_lim_prev_r  <= cw_travel_limit_input;
      idx_prev_r  <= encoder_index_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond base, restarted on each state change

  assign state_chg = state_nxt != state_r;
  assign ms_tick   = div_cnt_r == 32'(MS_CYCLES - 1);

  // Divider and millisecond count within a state
  always_ff @(posedge mclk) begin
    if (srst || state_chg) begin
      div_cnt_r <= 32'h0;
      ms_cnt_r  <= 16'h0;
    end else if (ms_tick) begin
      div_cnt_r <= 32'h0;
      ms_cnt_r  <= ms_cnt_r + 16'h1;
    end else begin
      div_cnt_r <= div_cnt_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence control

  // Reference event and search directions
  assign ref_evt =
    (homing_reference_mode == REF_SW_CCW ||
     homing_reference_mode == REF_SW_CW)  ? ref_rise :
    (homing_reference_mode == REF_CCW_LIM) ? ccw_lim_fall :
    (homing_reference_mode == REF_CW_LIM)  ? cw_lim_fall :
    (homing_reference_mode == REF_IDX_CCW ||
     homing_reference_mode == REF_IDX_CW) ? idx_rise : 1'b0;
  assign dir1_cw = homing_reference_mode[0];
  assign dir2_cw = (homing_origin_mode == ORG_FWD) ?
                   dir1_cw : !dir1_cw;

  // Start only from idle, so triggers during a run are dropped
  assign start_req = (state_r == ST_IDLE) &&
    ((homing_trigger_mode == TRIG_LEVEL && req_s2_r) ||
     (homing_trigger_mode == TRIG_EDGE && req_rise) ||
     (homing_trigger_mode == TRIG_POWERUP && pwrup_pend_r));

  assign ref_found   = state_r == ST_SEEK_REF && ref_evt;
  assign org_found   = (ref_found && homing_origin_mode == ORG_REF) ||
                       (state_r == ST_SEEK_ORG && idx_rise);
  assign settle_over = state_r == ST_SETTLE &&
                       ms_cnt_r >= homing_settle_delay;
  assign hold_over   = ms_cnt_r >= homing_done_hold_time;

  // Speed target per phase
  assign target =
    (state_r == ST_SEEK_REF) ?
      dir_speed(homing_first_speed, dir1_cw) :
    (state_r == ST_SEEK_ORG) ?
      dir_speed(homing_second_speed, dir2_cw) : 16'sd0;

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_req) state_nxt = ST_SEEK_REF;
      end
      ST_SEEK_REF: begin
        if (homing_trigger_mode == TRIG_OFF) state_nxt = ST_IDLE;
        else if (org_found) state_nxt = ST_SETTLE;
        else if (ref_found) state_nxt = ST_SEEK_ORG;
      end
      ST_SEEK_ORG: begin
        if (homing_trigger_mode == TRIG_OFF) state_nxt = ST_IDLE;
        else if (org_found) state_nxt = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (homing_trigger_mode == TRIG_OFF) state_nxt = ST_IDLE;
        else if (settle_over) state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        if (homing_trigger_mode == TRIG_OFF) state_nxt = ST_IDLE;
        else if (homing_trigger_mode == TRIG_LEVEL) begin
          if (!req_s2_r) state_nxt = ST_IDLE;
        end else if (hold_over) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  assign busy_nxt = state_nxt == ST_SEEK_REF ||
                    state_nxt == ST_SEEK_ORG ||
                    state_nxt == ST_SETTLE;
  assign done_nxt = state_nxt == ST_HOLD;

  // State, flags and registered outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r         <= ST_IDLE;
      pwrup_pend_r    <= 1'b1;
      homing_busy     <= 1'b0;
      homing_done     <= 1'b0;
      ccw_inhibit_en  <= 1'b1;
      cw_inhibit_en   <= 1'b1;
      cmd_enable      <= 1'b1;
      origin_position <= 32'sh0;
    end else begin
      state_r     <= state_nxt;
      homing_busy <= busy_nxt;
      homing_done <= done_nxt;
      if (start_req && homing_trigger_mode == TRIG_POWERUP)
        pwrup_pend_r <= 1'b0;
      ccw_inhibit_en <= !(busy_nxt &&
                          homing_reference_mode == REF_CCW_LIM);
      cw_inhibit_en  <= !(busy_nxt &&
                          homing_reference_mode == REF_CW_LIM);
      cmd_enable <= !busy_nxt &&
                    (post_homing_command_mode || !done_nxt);
      if (org_found)
        origin_position <= position_count +
          pulse_offset(origin_offset_high, origin_offset_low);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, new events win

  assign irq_evt = {settle_over, org_found, ref_found};
  assign irq_stat_nxt = (irq_stat_r &
    ~((wr_stb && addr == REG_IRQ_STAT) ? wdata[IRQ_W-1:0] : '0)) |
    irq_evt;

  // Sticky status and level interrupt
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat_r <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq        <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed ramp

  speed_ramp #(
    .RATED_RPM (RATED_RPM)
  ) u_ramp (
    .mclk     (mclk),
    .srst     (srst),
    .ms_tick  (ms_tick),
    .target   (target),
    .accel_ms (homing_accel_time),
    .decel_ms (homing_decel_time),
    .speed_r  (speed_cmd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_disabled_stays_idle : assert property (
    @(posedge mclk) disable iff (srst)
    (homing_trigger_mode == TRIG_OFF) |=> !homing_busy)
    else $error("homing ran while disabled");

  a_ref_search_dir : assert property (
    @(posedge mclk) disable iff (srst)
    (state_r == ST_SEEK_REF) |->
      target == (homing_reference_mode[0] ?
                 -signed'(homing_first_speed) :
                 signed'(homing_first_speed)))
    else $error("reference search speed or direction wrong");

  a_limit_inhibit_lift : assert property (
    @(posedge mclk) disable iff (srst)
    (!homing_busy && $past(!homing_busy)) |-> ccw_inhibit_en &&
      cw_inhibit_en)
    else $error("limit inhibit not restored");

  a_origin_dir : assert property (
    @(posedge mclk) disable iff (srst)
    (state_r == ST_SEEK_ORG && homing_origin_mode == ORG_BACK &&
     homing_second_speed != 16'h0) |->
      ((target < 16'sd0) != homing_reference_mode[0]))
    else $error("origin search not reversed");

  a_origin_offset : assert property (
    @(posedge mclk) disable iff (srst)
    org_found |=> origin_position == $past(position_count) +
      ($past(32'(origin_offset_high)) * 32'sd10000) +
      $past(32'(origin_offset_low)))
    else $error("origin offset wrong");

  a_done_after_settle : assert property (
    @(posedge mclk) disable iff (srst)
    $rose(homing_done) |-> $past(state_r) == ST_SETTLE &&
      $past(ms_cnt_r) >= $past(homing_settle_delay))
    else $error("done raised before settle delay");

  a_done_hold_time : assert property (
    @(posedge mclk) disable iff (srst)
    ($fell(homing_done) && $past(homing_trigger_mode[1])) |->
      $past(ms_cnt_r) >= $past(homing_done_hold_time))
    else $error("done dropped before hold time");

  a_cmd_wait_done : assert property (
    @(posedge mclk) disable iff (srst)
    (homing_busy || (homing_done && !$past(post_homing_command_mode)))
      |-> !cmd_enable)
    else $error("commands enabled too early");

  a_start_from_idle : assert property (
    @(posedge mclk) disable iff (srst)
    (state_r != ST_IDLE && state_r != ST_SEEK_REF) |=>
      state_r != ST_SEEK_REF)
    else $error("homing restarted while running");

endmodule
`default_nettype wire

// *** verilog/speed_ramp.sv ***
// Speed command ramp with accel and decel times referred to rated speed
`timescale 1ns/1ns
`default_nettype none
module speed_ramp
  import homing_pkg::*;
#(
  parameter int unsigned RATED_RPM = RATED_RPM_DFLT
) (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic               ms_tick,
  input  wire logic signed [15:0] target,
  input  wire logic        [15:0] accel_ms,
  input  wire logic        [15:0] decel_ms,
  output var  logic signed [15:0] speed_r
);

  logic [17:0] acc_r;
  logic        use_accel;
  logic [17:0] step_time;
  logic        going_up;

  // Magnitude grows from rest or away from zero on the same side
  assign use_accel = (speed_r == 16'sd0) ||
                     (speed_r > 16'sd0 && target > speed_r) ||
                     (speed_r < 16'sd0 && target < speed_r);
  assign step_time = {2'h0, (use_accel ? accel_ms : decel_ms)};
  assign going_up  = target > speed_r;

  // Rated speed credited per ms, one r/min step per time unit spent
  always_ff @(posedge mclk) begin
    if (srst) begin
      speed_r <= 16'sd0;
      acc_r   <= 18'h0;
    end else if (speed_r == target) begin
      acc_r <= 18'h0;
    end else if (step_time == 18'h0) begin
      speed_r <= target;
    end else if (acc_r >= step_time) begin
      acc_r   <= acc_r - step_time;
      speed_r <= going_up ? speed_r + 16'sd1 : speed_r - 16'sd1;
    end else if (ms_tick) begin
      acc_r <= acc_r + 18'(RATED_RPM);
    end
  end

  // Ramp assertions
  a_ramp_step_one : assert property (
    @(posedge mclk) disable iff (srst)
    (step_time != 18'h0 && speed_r != target) |=>
      (speed_r - $past(speed_r) <= 16'sd1) &&
      ($past(speed_r) - speed_r <= 16'sd1))
    else $error("ramp moved more than one step");

  a_ramp_decel_zero : assert property (
    @(posedge mclk) disable iff (srst)
    (!use_accel && decel_ms == 16'h0 && speed_r != target) |=>
      speed_r == $past(target))
    else $error("zero decel time did not jump");

endmodule
`default_nettype wire
